// ---- inc/mass_params.svh ----
// Constants for the multiplexed ADC scan sequencer.
`ifndef MASS_PARAMS_SVH
`define MASS_PARAMS_SVH
`define MASS_CLK_HZ 40000000
`define MASS_TB_1MHZ_HZ 1000000
`define MASS_TB_DIV_1MHZ (`MASS_CLK_HZ / `MASS_TB_1MHZ_HZ)
`define MASS_TB_STEP 10
`define MASS_TB_1MHZ 3'h0
`define MASS_TB_100KHZ 3'h1
`define MASS_TB_10KHZ 3'h2
`define MASS_TB_1KHZ 3'h3
`define MASS_TB_100HZ 3'h4
`define MASS_DIRECT_MAX_US 65535
`define MASS_RANGE_UNIPOLAR 1'h0
`define MASS_RANGE_BIPOLAR 1'h1
`define MASS_GAIN_1 3'h0
`define MASS_GAIN_2 3'h1
`define MASS_GAIN_5 3'h2
`define MASS_GAIN_10 3'h3
`define MASS_GAIN_20 3'h4
`define MASS_GAIN_50 3'h5
`define MASS_GAIN_100 3'h6
`define MASS_BIPOLAR_OFFSET 12'h800
`define MASS_REG_CTRL 4'h0
`define MASS_REG_GAIN 4'h1
`define MASS_REG_SCANLEN 4'h2
`define MASS_REG_INTERVAL 4'h3
`define MASS_REG_PRESCALE 4'h4
`define MASS_REG_COUNT 4'h5
`define MASS_REG_SCANIVL 4'h6
`define MASS_REG_STATUS 4'h7
`define MASS_REG_IRQ 4'h8
`define MASS_REG_MASK 4'h9
`define MASS_REG_DATA 4'hA
`define MASS_REG_PSOWN 4'hB
`define MASS_IRQ_DONE 0
`define MASS_IRQ_SAMPLE 1
`define MASS_IRQ_DENIED 2
`define MASS_TB_DIV_BASE 14'h0001
`define MASS_TB_DIV_100KHZ 14'h000A
`define MASS_TB_DIV_10KHZ 14'h0064
`define MASS_TB_DIV_1KHZ 14'h03E8
`define MASS_TB_DIV_100HZ 14'h2710
`endif

// ---- inc/mass_pkg.sv ----
// Types for the multiplexed ADC scan sequencer.
package mass_pkg;
	typedef enum logic [1:0] {mass_idle, mass_armed, mass_run, mass_wait_scan} mass_state_e;
	typedef enum logic [1:0] {mass_ps_free, mass_ps_acq, mass_ps_gpc, mass_ps_wave} mass_ps_owner_e;
endpackage : mass_pkg

// ---- hw/mass_sequencer.sv ----
// Scan sequencer for an eight-channel multiplexed 12-bit converter.
// Operation
// - Eight channels, one mux, one 12-bit converter.
// - Seven selectable gain codes.
// - Unipolar or bipolar range, code interpretation.
// - Single mode holds channel and gain.
// - Scan mode steps channels, single gain.
// - Wrap to first channel until count done.
// - Scan interval between pass starts.
// - Acquisition starts on trigger edge.
// - Conversion from interval counter or external.
// - Sample counter stops acquisition timing.
// - Five selectable interval timebases.
// - Prescaler cascades for long intervals.
// - General counter cannot claim held prescaler.
// - Waveform with other timebase is refused while acquisition holds prescaler.
// - Prescaler granted only when free.
// - Same timebase and prescale share prescaler with waveform.
`timescale 1ns/1ps
`default_nettype none
`include "mass_params.svh"
module mass_sequencer #(
	parameter int COUNT_W = 16,
	parameter int DATA_W = 12
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic external_trigger_in,
	input wire logic external_convert_in_n,
	output logic [2:0] mux_channel_out,
	output logic [2:0] gain_code_out,
	output logic range_bipolar_out,
	output logic convert_start_out,
	input wire logic adc_done_in,
	input wire logic [DATA_W-1:0] adc_data_in,
	input wire logic wave_active_in,
	input wire logic wave_uses_prescale_in,
	input wire logic [2:0] wave_timebase_in,
	input wire logic [COUNT_W-1:0] wave_prescale_in,
	input wire logic wave_claim_in,
	output logic wave_denied_out,
	output logic acq_active_out,
	output logic irq_out
);
	typedef struct packed {
		mass_pkg::mass_state_e state;
		mass_pkg::mass_ps_owner_e ps_owner;
		logic gpc_configured;
		logic scan_mode;
		logic ext_conv;
		logic interval_scan;
		logic bipolar;
		logic [2:0] timebase;
		logic [2:0] gain;
		logic [2:0] first_chan;
		logic [2:0] scan_len;
		logic [2:0] chan;
		logic [2:0] chan_step;
		logic [COUNT_W-1:0] interval;
		logic [COUNT_W-1:0] prescale;
		logic use_prescale;
		logic [COUNT_W-1:0] count;
		logic [COUNT_W-1:0] scan_ivl;
		logic [COUNT_W-1:0] done_cnt;
		logic [COUNT_W-1:0] int_cnt;
		logic [COUNT_W-1:0] ps_cnt;
		logic [COUNT_W-1:0] scan_cnt;
		logic [5:0] base_cnt;
		logic [13:0] tb_cnt;
		logic trig_d;
		logic conv_d;
		logic [DATA_W-1:0] data;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic conv;
		logic denied;
		logic [31:0] rdata;
		logic wait_req;
		logic active;
		logic irq;
	} mass_state_s;
	mass_state_s cur;
	mass_state_s next_cur;
	logic tb_tick;
	logic [13:0] tb_div;
	logic int_tick;
	logic ext_pulse;
	logic conv_pulse;
	logic trig_edge;
	logic wr;
	logic rd;
	logic [2:0] ev;
	always_comb begin
		// Each timebase step is ten times the last one, counted in 1 MHz ticks.
		case (cur.timebase)
			`MASS_TB_100KHZ: tb_div = `MASS_TB_DIV_100KHZ;
			`MASS_TB_10KHZ: tb_div = `MASS_TB_DIV_10KHZ;
			`MASS_TB_1KHZ: tb_div = `MASS_TB_DIV_1KHZ;
			`MASS_TB_100HZ: tb_div = `MASS_TB_DIV_100HZ;
			default: tb_div = `MASS_TB_DIV_BASE;
		endcase
	end
	always_comb begin
		next_cur = cur;
		ev = 3'h0;
		tb_tick = 1'b0;
		int_tick = 1'b0;
		// A write lands on the edge where the master sees waitrequest low, never earlier.
		wr = avs_write_in && !cur.wait_req;
		rd = avs_read_in && cur.wait_req;
		next_cur.wait_req = !((avs_read_in || avs_write_in) && cur.wait_req);
		next_cur.trig_d = external_trigger_in;
		next_cur.conv_d = external_convert_in_n;
		trig_edge = external_trigger_in && !cur.trig_d;
		ext_pulse = cur.conv_d && !external_convert_in_n;
		next_cur.conv = 1'b0;
		next_cur.denied = 1'b0;
		if (cur.base_cnt == 6'(`MASS_TB_DIV_1MHZ - 1)) begin
			next_cur.base_cnt = 6'h00;
			if (cur.tb_cnt >= tb_div - 14'h0001) begin
				next_cur.tb_cnt = 14'h0000;
				tb_tick = 1'b1;
			end else begin
				next_cur.tb_cnt = cur.tb_cnt + 14'h0001;
			end
		end else begin
			next_cur.base_cnt = cur.base_cnt + 6'h01;
		end
		// The prescaler divides the timebase when the interval is too long alone.
		if (cur.use_prescale && tb_tick) begin
			if (cur.ps_cnt <= COUNT_W'(1)) begin
				next_cur.ps_cnt = cur.prescale;
				int_tick = 1'b1;
			end else begin
				next_cur.ps_cnt = cur.ps_cnt - COUNT_W'(1);
			end
		end else if (!cur.use_prescale) begin
			int_tick = tb_tick;
		end
		// Pulses count only in the run state, so pulses before the trigger are dropped.
		conv_pulse = 1'b0;
		if (cur.state == mass_pkg::mass_run && int_tick && !cur.ext_conv) begin
			if (cur.int_cnt <= COUNT_W'(1)) begin
				next_cur.int_cnt = cur.interval;
				conv_pulse = 1'b1;
			end else begin
				next_cur.int_cnt = cur.int_cnt - COUNT_W'(1);
			end
		end
		if (cur.state == mass_pkg::mass_run && cur.ext_conv && ext_pulse) begin
			conv_pulse = 1'b1;
		end
		// The scan timer is reloaded at each pass start, so the interval spans whole passes.
		if (cur.interval_scan && cur.scan_mode && tb_tick && cur.scan_cnt != '0) begin
			next_cur.scan_cnt = cur.scan_cnt - COUNT_W'(1);
		end
		case (cur.state)
			mass_pkg::mass_idle: begin
				// Idle waits for software to arm the sequencer.
			end
			mass_pkg::mass_armed: begin
				// External pulses here are dropped so the first sample is the first channel.
				if (trig_edge) begin
					next_cur.state = mass_pkg::mass_run;
					next_cur.chan = cur.first_chan;
					next_cur.chan_step = 3'h0;
					next_cur.int_cnt = cur.interval;
					next_cur.ps_cnt = cur.prescale;
					next_cur.scan_cnt = cur.scan_ivl;
					next_cur.done_cnt = '0;
				end
			end
			mass_pkg::mass_run: begin
				if (conv_pulse) begin
					next_cur.conv = 1'b1;
					next_cur.done_cnt = cur.done_cnt + COUNT_W'(1);
					if (cur.done_cnt + COUNT_W'(1) >= cur.count) begin
						next_cur.state = mass_pkg::mass_idle;
						ev[`MASS_IRQ_DONE] = 1'b1;
					end
				end else if (cur.conv && cur.scan_mode) begin
					// Step a cycle after the pulse, so the converter samples the channel it was told.
					if (cur.chan_step >= cur.scan_len) begin
						next_cur.chan_step = 3'h0;
						next_cur.chan = cur.first_chan;
						if (cur.interval_scan) begin
							next_cur.state = mass_pkg::mass_wait_scan;
						end
					end else begin
						next_cur.chan_step = cur.chan_step + 3'h1;
						next_cur.chan = cur.chan + 3'h1;
					end
				end
			end
			mass_pkg::mass_wait_scan: begin
				if (cur.scan_cnt == '0) begin
					next_cur.scan_cnt = cur.scan_ivl;
					next_cur.int_cnt = cur.interval;
					next_cur.state = mass_pkg::mass_run;
				end
			end
			default: next_cur.state = mass_pkg::mass_idle;
		endcase
		if (adc_done_in) begin
			// Bipolar codes are offset binary; flipping the top bit gives two's complement.
			next_cur.data = cur.bipolar ? adc_data_in ^ DATA_W'(`MASS_BIPOLAR_OFFSET) : adc_data_in;
			ev[`MASS_IRQ_SAMPLE] = 1'b1;
		end
		// The prescaler is handed back as soon as the run ends, so a general counter may take it.
		if (cur.ps_owner == mass_pkg::mass_ps_acq && next_cur.state == mass_pkg::mass_idle) begin
			next_cur.ps_owner = mass_pkg::mass_ps_free;
			next_cur.use_prescale = 1'b0;
		end
		// A claim matching the running setup shares the prescaler instead of being refused.
		if (wave_claim_in) begin
			if (cur.ps_owner == mass_pkg::mass_ps_acq && wave_timebase_in == cur.timebase
				&& wave_prescale_in == cur.prescale) begin
				next_cur.denied = 1'b0;
			end else if (cur.ps_owner == mass_pkg::mass_ps_acq || cur.ps_owner == mass_pkg::mass_ps_gpc) begin
				next_cur.denied = 1'b1;
				ev[`MASS_IRQ_DENIED] = 1'b1;
			end
		end
		if (wr) begin
			if (avs_address_in == `MASS_REG_CTRL) begin
				next_cur.scan_mode = avs_writedata_in[1];
				next_cur.ext_conv = avs_writedata_in[2];
				next_cur.interval_scan = avs_writedata_in[3];
				next_cur.bipolar = avs_writedata_in[4];
				next_cur.timebase = avs_writedata_in[7:5];
				next_cur.use_prescale = 1'b0;
				if (avs_writedata_in[0] && cur.state == mass_pkg::mass_idle) begin
					if (avs_writedata_in[8]) begin
						// Grant only a free prescaler, or share one with the same setup.
						if (cur.ps_owner == mass_pkg::mass_ps_free && !wave_active_in) begin
							next_cur.ps_owner = mass_pkg::mass_ps_acq;
							next_cur.use_prescale = 1'b1;
							next_cur.state = mass_pkg::mass_armed;
						end else if (wave_active_in && wave_uses_prescale_in
							&& wave_timebase_in == avs_writedata_in[7:5]
							&& wave_prescale_in == cur.prescale) begin
							next_cur.use_prescale = 1'b1;
							next_cur.state = mass_pkg::mass_armed;
						end else begin
							next_cur.denied = 1'b1;
							ev[`MASS_IRQ_DENIED] = 1'b1;
						end
					end else begin
						next_cur.state = mass_pkg::mass_armed;
					end
				end else if (!avs_writedata_in[0]) begin
					next_cur.state = mass_pkg::mass_idle;
				end
			end else if (avs_address_in == `MASS_REG_GAIN) begin
				next_cur.gain = (avs_writedata_in[2:0] > `MASS_GAIN_100) ? `MASS_GAIN_100
					: avs_writedata_in[2:0];
				next_cur.first_chan = avs_writedata_in[6:4];
			end else if (avs_address_in == `MASS_REG_SCANLEN) begin
				next_cur.scan_len = avs_writedata_in[2:0];
			end else if (avs_address_in == `MASS_REG_INTERVAL) begin
				next_cur.interval = avs_writedata_in[COUNT_W-1:0];
			end else if (avs_address_in == `MASS_REG_PRESCALE) begin
				next_cur.prescale = avs_writedata_in[COUNT_W-1:0];
			end else if (avs_address_in == `MASS_REG_COUNT) begin
				next_cur.count = avs_writedata_in[COUNT_W-1:0];
			end else if (avs_address_in == `MASS_REG_SCANIVL) begin
				next_cur.scan_ivl = avs_writedata_in[COUNT_W-1:0];
			end else if (avs_address_in == `MASS_REG_IRQ) begin
				next_cur.irq_stat = cur.irq_stat & ~avs_writedata_in[2:0];
			end else if (avs_address_in == `MASS_REG_MASK) begin
				next_cur.irq_mask = avs_writedata_in[2:0];
			end else if (avs_address_in == `MASS_REG_PSOWN) begin
				// Bit 0 configures the general counter, bit 1 releases it.
				if (avs_writedata_in[0]) begin
					if (cur.ps_owner == mass_pkg::mass_ps_free
						&& !(wave_active_in && wave_uses_prescale_in)) begin
						next_cur.ps_owner = mass_pkg::mass_ps_gpc;
						next_cur.gpc_configured = 1'b1;
					end else if (cur.ps_owner != mass_pkg::mass_ps_gpc) begin
						next_cur.denied = 1'b1;
						ev[`MASS_IRQ_DENIED] = 1'b1;
					end
				end else if (avs_writedata_in[1]) begin
					if (cur.ps_owner == mass_pkg::mass_ps_gpc) begin
						next_cur.ps_owner = mass_pkg::mass_ps_free;
						next_cur.gpc_configured = 1'b0;
					end else if (cur.ps_owner == mass_pkg::mass_ps_acq) begin
						next_cur.denied = 1'b1;
						ev[`MASS_IRQ_DENIED] = 1'b1;
					end
				end
			end
		end
		// A new event wins over a clear in the same cycle.
		next_cur.irq_stat = next_cur.irq_stat | ev;
		// Outputs are registered from the next state, keeping the timing of the state itself.
		next_cur.irq = |(next_cur.irq_stat & next_cur.irq_mask);
		next_cur.active = next_cur.state != mass_pkg::mass_idle;
		next_cur.rdata = 32'h00000000;
		if (rd) begin
			if (avs_address_in == `MASS_REG_CTRL) begin
				next_cur.rdata = {23'h000000, cur.use_prescale, cur.timebase,
					cur.bipolar, cur.interval_scan, cur.ext_conv, cur.scan_mode,
					cur.state != mass_pkg::mass_idle};
			end else if (avs_address_in == `MASS_REG_GAIN) begin
				next_cur.rdata = {25'h0000000, cur.first_chan, 1'b0, cur.gain};
			end else if (avs_address_in == `MASS_REG_SCANLEN) begin
				next_cur.rdata = {29'h00000000, cur.scan_len};
			end else if (avs_address_in == `MASS_REG_INTERVAL) begin
				next_cur.rdata = 32'(cur.interval);
			end else if (avs_address_in == `MASS_REG_PRESCALE) begin
				next_cur.rdata = 32'(cur.prescale);
			end else if (avs_address_in == `MASS_REG_COUNT) begin
				next_cur.rdata = 32'(cur.count);
			end else if (avs_address_in == `MASS_REG_SCANIVL) begin
				next_cur.rdata = 32'(cur.scan_ivl);
			end else if (avs_address_in == `MASS_REG_STATUS) begin
				next_cur.rdata = {8'h00, 16'(cur.done_cnt), 1'b0, cur.chan,
					2'h0, cur.state};
			end else if (avs_address_in == `MASS_REG_IRQ) begin
				next_cur.rdata = {29'h00000000, cur.irq_stat};
			end else if (avs_address_in == `MASS_REG_MASK) begin
				next_cur.rdata = {29'h00000000, cur.irq_mask};
			end else if (avs_address_in == `MASS_REG_DATA) begin
				next_cur.rdata = 32'(cur.data);
			end else if (avs_address_in == `MASS_REG_PSOWN) begin
				next_cur.rdata = {29'h00000000, cur.gpc_configured, cur.ps_owner};
			end
		end
	end
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			cur <= '0;
			cur.state <= mass_pkg::mass_idle;
			cur.ps_owner <= mass_pkg::mass_ps_free;
			cur.interval <= COUNT_W'(1);
			cur.prescale <= COUNT_W'(1);
			cur.count <= COUNT_W'(1);
			cur.trig_d <= 1'b0;
			cur.conv_d <= 1'b1;
			// Outputs rest in reset; waitrequest stays high so no request is taken.
			cur.wait_req <= 1'b1;
			cur.active <= 1'b0;
			cur.irq <= 1'b0;
			cur.conv <= 1'b0;
			cur.denied <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end
	always_comb begin
		avs_readdata_out = cur.rdata;
		avs_waitrequest_out = cur.wait_req;
		mux_channel_out = cur.chan;
		gain_code_out = cur.gain;
		range_bipolar_out = cur.bipolar;
		convert_start_out = cur.conv;
		wave_denied_out = cur.denied;
		acq_active_out = cur.active;
		irq_out = cur.irq;
	end
endmodule : mass_sequencer
`default_nettype wire

// ---- testbench/mass_checker_assertions.sv ----
// Port assertions for the scan sequencer.
`timescale 1ns/1ps
`default_nettype none
module mass_checker (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic [2:0] gain_code_out,
	input wire logic range_bipolar_out,
	input wire logic convert_start_out,
	input wire logic acq_active_out,
	input wire logic wave_claim_in,
	input wire logic wave_denied_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	logic wr_ok;
	logic both_on;
	assign wr_ok = avs_write_in && !avs_waitrequest_out;
	assign both_on = acq_active_out && convert_start_out;
	conv_pulse_a: assert property (convert_start_out |=> !convert_start_out)
		else $error("convert pulse too long");
	conv_active_a: assert property (convert_start_out |-> acq_active_out || $past(acq_active_out))
		else $error("convert while idle");
	gain_legal_a: assert property (gain_code_out <= 3'h6)
		else $error("gain code out of range");
	gain_hold_a: assert property (both_on |-> $stable(gain_code_out))
		else $error("gain changed in run");
	range_hold_a: assert property (both_on |-> $stable(range_bipolar_out))
		else $error("range changed in run");
	deny_pulse_a: assert property (wave_denied_out |=> !wave_denied_out)
		else $error("deny pulse too long");
	deny_cause_a: assert property (wave_denied_out |-> $past(wave_claim_in) || $past(wr_ok))
		else $error("deny without claim");
	start_cause_a: assert property ($rose(acq_active_out) |-> $past(wr_ok) || $past(wr_ok, 2))
		else $error("armed without write");
	cover property (convert_start_out);
	cover property (wave_denied_out);
	cover property ($fell(acq_active_out));
endmodule : mass_checker
bind mass_sequencer mass_checker u_chk (.clock_in, .reset_in, .avs_write_in, .avs_waitrequest_out,
	.gain_code_out, .range_bipolar_out, .convert_start_out, .acq_active_out, .wave_claim_in,
	.wave_denied_out);
`default_nettype wire

// ---- testbench/mass_adc_model.sv ----
// Converter model answering each conversion start with one result.
`timescale 1ns/1ps
`default_nettype none
module mass_adc_model (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic convert_start_in,
	input wire logic [2:0] mux_channel_in,
	input wire logic slow_in,
	output logic adc_done_out,
	output logic [11:0] adc_data_out
);
	logic [4:0] wait_cnt = 5'h00;
	logic [11:0] sample = 12'h000;
	always @(posedge clock_in) begin
		adc_done_out <= 1'h0;
		if (reset_in) begin
			wait_cnt <= 5'h00;
		end else if (convert_start_in) begin
			wait_cnt <= slow_in ? 5'h14 : 5'h02;
			sample <= {mux_channel_in, 9'h0A5};
		end else if (wait_cnt != 5'h00) begin
			wait_cnt <= wait_cnt - 5'h01;
			adc_done_out <= (wait_cnt == 5'h01);
		end
	end
	// Outside the result pulse the lines show the complement, so stale data never looks valid.
	assign adc_data_out = adc_done_out ? sample : ~sample;
endmodule : mass_adc_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the scan sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "mass_params.svh"
module tb_top;
	typedef struct {logic [31:0] ctrl, gain, len, ivl, sivl; int n, tick;} mass_row_s;
	logic clock_in = 1'h0;
	logic reset_in = 1'h1;
	logic avs_read_in = 1'h0;
	logic avs_write_in = 1'h0;
	logic [3:0] avs_address_in = 4'h0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic external_trigger_in = 1'h0;
	logic external_convert_in_n = 1'h1;
	logic wave_active_in = 1'h0;
	logic wave_uses_prescale_in = 1'h0;
	logic wave_claim_in = 1'h0;
	logic [2:0] wave_timebase_in = 3'h0;
	logic [15:0] wave_prescale_in = 16'h0002;
	logic slow = 1'h0;
	logic saw_deny = 1'h0;
	logic avs_waitrequest_out, range_bipolar_out, convert_start_out, adc_done_in;
	logic wave_denied_out, acq_active_out, irq_out;
	logic [31:0] avs_readdata_out, rdv;
	logic [2:0] mux_channel_out, gain_code_out;
	logic [11:0] adc_data_in;
	logic [6:0] log_q [$];
	int gaps [$];
	int n_fail, n_tests, cyc, last_t, k;
	mass_row_s rows [4];
	mass_sequencer u_dut (.clock_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .external_trigger_in,
		.external_convert_in_n, .mux_channel_out, .gain_code_out, .range_bipolar_out,
		.convert_start_out, .adc_done_in, .adc_data_in, .wave_active_in, .wave_uses_prescale_in,
		.wave_timebase_in, .wave_prescale_in, .wave_claim_in, .wave_denied_out, .acq_active_out,
		.irq_out);
	mass_adc_model u_adc (.clock_in, .reset_in, .convert_start_in(convert_start_out),
		.mux_channel_in(mux_channel_out), .slow_in(slow), .adc_done_out(adc_done_in),
		.adc_data_out(adc_data_in));
	initial begin
		forever #12.5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (wave_denied_out === 1'h1) saw_deny = 1'h1;
		if (convert_start_out === 1'h1) begin
			log_q.push_back({range_bipolar_out, gain_code_out, mux_channel_out});
			gaps.push_back(cyc - last_t);
			last_t = cyc;
		end
	end
	task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp_v);
		n_tests++;
		if (seen_v !== exp_v) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp_v, seen_v);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		for (k = 0; k < 50; k++) begin
			@(posedge clock_in);
			if (avs_waitrequest_out === 1'h0) break;
		end
		rdv = avs_readdata_out;
		avs_write_in <= 1'h0;
		avs_read_in <= 1'h0;
		if (k == 50) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : bus
	task automatic wait_idle();
		for (k = 0; k < 40000 && acq_active_out !== 1'h0; k++) @(posedge clock_in);
		// One more edge lets the logger record the final pulse before it is counted.
		@(posedge clock_in);
		if (k == 40000) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : wait_idle
	task automatic pulse(input logic trig);
		@(posedge clock_in);
		if (trig) external_trigger_in <= 1'h1;
		else external_convert_in_n <= 1'h0;
		repeat (4) @(posedge clock_in);
		external_trigger_in <= 1'h0;
		external_convert_in_n <= 1'h1;
		repeat (trig ? 4 : 800) @(posedge clock_in);
	endtask : pulse
	task automatic claim(input logic [2:0] tb);
		saw_deny = 1'h0;
		wave_timebase_in <= tb;
		wave_claim_in <= 1'h1;
		@(posedge clock_in);
		wave_claim_in <= 1'h0;
		repeat (4) @(posedge clock_in);
	endtask : claim
	initial begin
		// Each interval covers the settling time of its gain.
		rows[0] = '{32'h031, 32'h56, 0, 10, 0, 3, 400};
		rows[1] = '{32'h003, 32'h20, 2, 16, 0, 7, 40};
		rows[2] = '{32'h043, 32'h61, 1, 2, 0, 3, 4000};
		rows[3] = '{32'h00B, 32'h30, 1, 16, 50, 4, 40};
		repeat (16) @(posedge clock_in);
		reset_in <= 1'h0;
		check("reset_outs", {acq_active_out, irq_out, avs_waitrequest_out, wave_denied_out}, 4'h2);
		bus(0, 4'hC, 32'h0);
		check("unmapped", rdv, 32'h0);
		for (int r = 0; r < 4; r++) begin
			slow <= r[0];
			bus(1, `MASS_REG_GAIN, rows[r].gain);
			bus(1, `MASS_REG_SCANLEN, rows[r].len);
			bus(1, `MASS_REG_INTERVAL, rows[r].ivl);
			bus(1, `MASS_REG_SCANIVL, rows[r].sivl);
			bus(1, `MASS_REG_COUNT, rows[r].n);
			bus(1, `MASS_REG_CTRL, rows[r].ctrl);
			log_q.delete();
			gaps.delete();
			pulse(1);
			wait_idle();
			check("samples", log_q.size(), rows[r].n);
			for (int i = 0; i < log_q.size(); i++) begin
				check("chan_gain", log_q[i], {rows[r].ctrl[4], rows[r].gain[2:0], rows[r].gain[6:4]
					+ 3'(i % (rows[r].len + 1))});
				if (i > 0) check("gap", gaps[i], rows[r].tick * ((i % (rows[r].len + 1) == 0
					&& rows[r].sivl != 0) ? rows[r].sivl - rows[r].len * rows[r].ivl : rows[r].ivl));
			end
			// A slow conversion lands well after the run has ended.
			repeat (32) @(posedge clock_in);
			bus(0, `MASS_REG_DATA, 32'h0);
			check("data", rdv, {log_q[$][2:0], 9'h0A5} ^ (rows[r].ctrl[4] ? 12'h800 : 12'h0));
			bus(0, `MASS_REG_IRQ, 32'h0);
			check("done", rdv[0], 1'h1);
			bus(1, `MASS_REG_IRQ, 32'h7);
		end
		bus(1, `MASS_REG_GAIN, 32'h17);
		bus(0, `MASS_REG_GAIN, 32'h0);
		check("gain_clamp", rdv, 32'h16);
		bus(1, `MASS_REG_GAIN, 32'h10);
		bus(1, `MASS_REG_SCANLEN, 32'h0);
		bus(1, `MASS_REG_CTRL, 32'h005);
		log_q.delete();
		repeat (2) pulse(0);
		check("pre_trigger", log_q.size(), 0);
		pulse(1);
		repeat (3) pulse(0);
		check("external", log_q.size(), 3);
		bus(1, `MASS_REG_CTRL, 32'h0);
		wait_idle();
		bus(1, `MASS_REG_MASK, 32'h0);
		bus(1, `MASS_REG_PRESCALE, 32'h2);
		bus(1, `MASS_REG_INTERVAL, 32'hA);
		bus(1, `MASS_REG_COUNT, 32'h3);
		bus(1, `MASS_REG_CTRL, 32'h101);
		gaps.delete();
		pulse(1);
		bus(1, `MASS_REG_PSOWN, 32'h1);
		bus(0, `MASS_REG_PSOWN, 32'h0);
		check("owner", rdv[1:0], 2'h1);
		wave_active_in <= 1'h1;
		wave_uses_prescale_in <= 1'h1;
		claim(3'h1);
		check("deny_other", saw_deny, 1'h1);
		check("irq_masked", irq_out, 1'h0);
		bus(1, `MASS_REG_MASK, 32'h4);
		repeat (2) @(posedge clock_in);
		check("irq_raised", irq_out, 1'h1);
		bus(1, `MASS_REG_IRQ, 32'h4);
		repeat (2) @(posedge clock_in);
		check("irq_cleared", irq_out, 1'h0);
		claim(3'h0);
		check("share_same", saw_deny, 1'h0);
		wait_idle();
		check("prescaled_gap", gaps[$], 800);
		bus(1, `MASS_REG_PSOWN, 32'h2);
		claim(3'h3);
		check("claim_free", saw_deny, 1'h0);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
